// [verilog/cgu_top.sv]
// Clock generation unit: source select, wake-up, divider and registers.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module cgu_top #(
    parameter logic [5:0] FACTORY_TRIM = cgu_pkg::FACTORY_TRIM_DEFAULT,
    parameter int WAKE_EXTRA_CYCLES = cgu_pkg::WAKE_EXTRA_CYCLES
) (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic por_n,
    // Configuration and neighbours
    input wire logic [2:0] osc_config,
    input wire logic rtc_uses_crystal,
    input wire logic wake_request,
    // Oscillator inputs
    input wire logic crystal_in_pin,
    input wire logic rc_osc_clock,
    input wire logic wdt_osc_clock,
    // Port logic for the crystal output pin
    input wire logic port_out,
    input wire logic port_oe,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Generated clocks
    output logic root_osc_clock,
    output logic cpu_clock,
    output logic cpu_clock_tick,
    output logic periph_clock,
    output logic machine_cycle_tick,
    // Oscillator controls
    output logic crystal_amp_enable,
    output logic [1:0] crystal_range,
    output logic rc_osc_enable,
    output logic [5:0] rc_trim,
    output logic low_power_clocking_bit,
    // Crystal output or clock pin
    output logic crystal_out_or_clock_pin_out,
    output logic crystal_out_or_clock_pin_oe
);

    localparam int NS = cgu_pkg::NUM_SRC;
    localparam int DW = cgu_pkg::DIV_W;

    // Root source index for a configuration code; illegal codes use RC.
    function automatic logic [1:0] src_of(input logic [2:0] c);
        logic [1:0] s;
        s = cgu_pkg::SRC_RC;
        case (c)
            cgu_pkg::CFG_XTAL_LOW, cgu_pkg::CFG_XTAL_MED,
            cgu_pkg::CFG_XTAL_HIGH, cgu_pkg::CFG_EXT:
                s = cgu_pkg::SRC_XTAL;
            cgu_pkg::CFG_WDT:
                s = cgu_pkg::SRC_WDT;
            default:
                s = cgu_pkg::SRC_RC;
        endcase
        return s;
    endfunction

    // Crystal amplifier range for a configuration code.
    function automatic logic [1:0] range_of(input logic [2:0] c);
        logic [1:0] r;
        r = cgu_pkg::RANGE_OFF;
        case (c)
            cgu_pkg::CFG_XTAL_LOW: r = cgu_pkg::RANGE_LOW;
            cgu_pkg::CFG_XTAL_MED: r = cgu_pkg::RANGE_MED;
            cgu_pkg::CFG_XTAL_HIGH: r = cgu_pkg::RANGE_HIGH;
            default: r = cgu_pkg::RANGE_OFF;
        endcase
        return r;
    endfunction

    // Configuration capture and source decode.
    logic [2:0] cfg_reg;
    logic cfg_valid_reg;
    logic wake_start_reg;
    logic [1:0] src_sel;
    logic xtal_used;
    logic xtal_busy;

    assign src_sel = src_of(cfg_reg);
    assign xtal_used = (range_of(cfg_reg) != cgu_pkg::RANGE_OFF);
    assign xtal_busy = xtal_used || rtc_uses_crystal;

    // The strap is caught once, on the first edge after reset release,
    // and the wake-up timer is started with it.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cfg_reg <= cgu_pkg::CFG_RC;
            cfg_valid_reg <= 1'b0;
            wake_start_reg <= 1'b0;
        end
        else
        begin
            if (!cfg_valid_reg)
                cfg_reg <= osc_config;
            cfg_valid_reg <= 1'b1;
            wake_start_reg <= !cfg_valid_reg || wake_request;
        end
    end

    // Oscillator sampling: three stages, a change counts once the
    // second and third stages agree.
    logic [NS-1:0] osc_raw;
    logic [NS-1:0] s1_reg;
    logic [NS-1:0] s2_reg;
    logic [NS-1:0] s3_reg;
    logic [NS-1:0] lvl_reg;
    logic [NS-1:0] agree;
    logic [NS-1:0] lvl_next;
    logic root_prev_reg;
    logic root_level;
    logic root_tick;

    assign osc_raw = {wdt_osc_clock, rc_osc_clock, crystal_in_pin};
    assign agree = ~(s2_reg ^ s3_reg);
    assign lvl_next = (agree & s3_reg) | (~agree & lvl_reg);
    assign root_level = lvl_reg[src_sel];
    assign root_tick = root_level && !root_prev_reg;

    // Sampling chain and root edge history.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            lvl_reg <= '0;
            root_prev_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= osc_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
            root_prev_reg <= root_level;
        end
    end

    // Avalon-MM decode: every access waits one cycle, then completes.
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_word;
    logic req;
    logic wr_fire;
    logic hit_trim;
    logic hit_aux1;
    logic hit_div;
    logic hit_status;

    assign req = avs_read || avs_write;
    assign wr_fire = avs_write && !wait_reg && avs_byteenable[0];
    assign hit_trim = (avs_address == cgu_pkg::OFS_TRIM);
    assign hit_aux1 = (avs_address == cgu_pkg::OFS_AUX1);
    assign hit_div = (avs_address == cgu_pkg::OFS_DIV);
    assign hit_status = (avs_address == cgu_pkg::OFS_STATUS);

    // Register state.
    logic [5:0] trim_reg;
    logic pin_en_reg;
    logic lp_reg;
    logic [DW-1:0] div_reg;
    logic wake_done;
    logic cpu_clk;

    // Read mux; unmapped offsets and reserved bits read as zero.
    always_comb
    begin
        rd_word = '0;
        if (hit_trim)
        begin
            rd_word[cgu_pkg::TRIM_LSB +: cgu_pkg::TRIM_W] = trim_reg;
            rd_word[cgu_pkg::PIN_EN_BIT] = pin_en_reg;
        end
        if (hit_aux1)
            rd_word[cgu_pkg::LPCLK_BIT] = lp_reg;
        if (hit_div)
            rd_word[cgu_pkg::DIV_LSB +: DW] = div_reg;
        if (hit_status)
        begin
            rd_word[cgu_pkg::ST_CFG_LSB +: cgu_pkg::ST_CFG_W] = cfg_reg;
            rd_word[cgu_pkg::ST_WAKE_BIT] = wake_done;
            rd_word[cgu_pkg::ST_CPU_BIT] = cpu_clk;
            rd_word[cgu_pkg::ST_XTAL_BIT] = xtal_busy;
        end
    end

    // Bus handshake and read data capture.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end
        else
        begin
            wait_reg <= !(req && wait_reg);
            if (avs_read && wait_reg)
                rdata_reg <= rd_word;
        end
    end

    // Trim register kept across every reset except power-on.
    always_ff @(posedge sys_clk or negedge por_n)
    begin
        if (!por_n)
        begin
            trim_reg <= FACTORY_TRIM;
            pin_en_reg <= 1'b0;
        end
        else if (wr_fire && hit_trim)
        begin
            trim_reg <= avs_writedata[cgu_pkg::TRIM_LSB +: cgu_pkg::TRIM_W];
            pin_en_reg <= avs_writedata[cgu_pkg::PIN_EN_BIT];
        end
    end

    // Divider value and low-power bit, cleared whenever rstn is low.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_reg <= cgu_pkg::DIV_RESET;
            lp_reg <= 1'b0;
        end
        else
        begin
            if (wr_fire && hit_div)
                div_reg <= avs_writedata[cgu_pkg::DIV_LSB +: DW];
            if (wr_fire && hit_aux1)
                lp_reg <= avs_writedata[cgu_pkg::LPCLK_BIT];
        end
    end

    // Wake-up timer; crystals take the longer root count.
    cgu_wakeup #(
        .EXTRA_CYCLES(WAKE_EXTRA_CYCLES),
        .CNT_W(cgu_pkg::WAKE_CNT_W)
    ) u_wakeup (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .start(wake_start_reg),
        .long_delay(xtal_used),
        .root_tick(root_tick),
        .done(wake_done)
    );

    // CPU clock divider, held stopped until the wake-up timer is done.
    logic cpu_rise;

    cgu_divider #(
        .DIV_W(DW)
    ) u_divider (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .hold(!wake_done),
        .root_tick(root_tick),
        .root_level(root_level),
        .div_value(div_reg),
        .cpu_clock(cpu_clk),
        .cpu_rise(cpu_rise)
    );

    // Derived clocks and the crystal output pin.
    logic pclk_reg;
    logic mc_phase_reg;
    logic mc_tick_reg;
    logic amp_reg;
    logic [1:0] range_reg;
    logic rc_en_reg;
    logic pin_out_reg;
    logic pin_oe_reg;
    logic pin_clk_on;

    assign pin_clk_on = pin_en_reg && !xtal_busy;

    // Peripheral clock and machine cycle follow CPU clock rising edges.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pclk_reg <= 1'b0;
            mc_phase_reg <= 1'b0;
            mc_tick_reg <= 1'b0;
        end
        else
        begin
            if (cpu_rise)
            begin
                pclk_reg <= !pclk_reg;
                mc_phase_reg <= !mc_phase_reg;
            end
            mc_tick_reg <= cpu_rise && mc_phase_reg;
        end
    end

    // Oscillator controls and pin drivers, registered.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            amp_reg <= 1'b0;
            range_reg <= cgu_pkg::RANGE_OFF;
            rc_en_reg <= 1'b0;
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end
        else
        begin
            amp_reg <= cfg_valid_reg && xtal_used;
            range_reg <= range_of(cfg_reg);
            rc_en_reg <= cfg_valid_reg && (src_sel == cgu_pkg::SRC_RC);
            pin_out_reg <= pin_clk_on ? pclk_reg : port_out;
            pin_oe_reg <= (xtal_busy || !cfg_valid_reg) ? 1'b0 :
                          pin_clk_on ? 1'b1 : port_oe;
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign root_osc_clock = root_prev_reg;
    assign cpu_clock = cpu_clk;
    assign cpu_clock_tick = cpu_rise;
    assign periph_clock = pclk_reg;
    assign machine_cycle_tick = mc_tick_reg;
    assign crystal_amp_enable = amp_reg;
    assign crystal_range = range_reg;
    assign rc_osc_enable = rc_en_reg;
    assign rc_trim = trim_reg;
    assign low_power_clocking_bit = lp_reg;
    assign crystal_out_or_clock_pin_out = pin_out_reg;
    assign crystal_out_or_clock_pin_oe = pin_oe_reg;

endmodule

// [include/cgu_pkg.sv]
// Shared constants and types of the clock generation unit.
package cgu_pkg;

    // Nonvolatile oscillator configuration codes; 3'h6 and 3'h7 are illegal.
    typedef enum logic [2:0] {
        CFG_XTAL_LOW = 3'h0,
        CFG_XTAL_MED = 3'h1,
        CFG_XTAL_HIGH = 3'h2,
        CFG_RC = 3'h3,
        CFG_WDT = 3'h4,
        CFG_EXT = 3'h5
    } cgu_osc_cfg_type;

    // Index of each oscillator input in the sampled source vector.
    localparam int NUM_SRC = 3;
    localparam logic [1:0] SRC_XTAL = 2'h0;
    localparam logic [1:0] SRC_RC = 2'h1;
    localparam logic [1:0] SRC_WDT = 2'h2;

    // Crystal amplifier range codes.
    localparam logic [1:0] RANGE_OFF = 2'h0;
    localparam logic [1:0] RANGE_LOW = 2'h1;
    localparam logic [1:0] RANGE_MED = 2'h2;
    localparam logic [1:0] RANGE_HIGH = 2'h3;

    // Register byte offsets.
    localparam logic [3:0] OFS_TRIM = 4'h0;
    localparam logic [3:0] OFS_AUX1 = 4'h4;
    localparam logic [3:0] OFS_DIV = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;

    // Field positions.
    localparam int TRIM_LSB = 0;
    localparam int TRIM_W = 6;
    localparam int PIN_EN_BIT = 6;
    localparam int LPCLK_BIT = 7;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 8;
    localparam int ST_CFG_LSB = 0;
    localparam int ST_CFG_W = 3;
    localparam int ST_WAKE_BIT = 3;
    localparam int ST_CPU_BIT = 4;
    localparam int ST_XTAL_BIT = 5;

    // Reset values.
    localparam logic [5:0] FACTORY_TRIM_DEFAULT = 6'h20;
    localparam logic [7:0] DIV_RESET = 8'h00;

    // Wake-up delay figures.
    localparam int WAKE_XTAL_ROOT_CYCLES = 992;
    localparam int WAKE_OTHER_ROOT_CYCLES = 224;
    localparam int SYS_CLK_PERIOD_NS = 5;
    localparam int WAKE_EXTRA_MIN_US = 60;
    localparam int WAKE_EXTRA_MAX_US = 100;
    localparam int WAKE_EXTRA_CYCLES =
        (WAKE_EXTRA_MIN_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int WAKE_CNT_W = 16;

endpackage

// [verilog/cgu_divider.sv]
// Programmable root clock divider producing the CPU clock.
`timescale 1ns/10ps
module cgu_divider #(
    parameter int DIV_W = cgu_pkg::DIV_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Root clock and control
    input wire logic hold,
    input wire logic root_tick,
    input wire logic root_level,
    input wire logic [DIV_W-1:0] div_value,
    // CPU clock
    output logic cpu_clock,
    output logic cpu_rise
);

    logic [DIV_W-1:0] active_reg;
    logic [DIV_W-1:0] cnt_reg;
    logic clk_reg;
    logic rise_reg;
    logic [DIV_W-1:0] active_next;
    logic [DIV_W-1:0] cnt_next;
    logic clk_next;
    logic bypass;
    logic terminal;
    logic boundary;

    // A zero ratio passes the root clock; otherwise each phase lasts
    // the programmed number of root periods.
    assign bypass = (active_reg == '0);
    assign terminal = root_tick &&
        (cnt_reg == DIV_W'(active_reg - 1'b1));
    assign boundary = bypass ? root_tick : (terminal && !clk_reg);

    // A new ratio is taken while held, otherwise only at the start of a CPU clock period.
    assign active_next = (hold || boundary) ? div_value
                                            : active_reg;
    assign clk_next = hold ? 1'b0 :
                      bypass ? root_level :
                      terminal ? ~clk_reg : clk_reg;
    assign cnt_next = (hold || bypass || terminal) ? '0 :
                      root_tick ? DIV_W'(cnt_reg + 1'b1) : cnt_reg;

    // Divider state.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_reg <= '0;
            cnt_reg <= '0;
            clk_reg <= 1'b0;
            rise_reg <= 1'b0;
        end
        else
        begin
            active_reg <= active_next;
            cnt_reg <= cnt_next;
            clk_reg <= clk_next;
            rise_reg <= !hold && boundary;
        end
    end

    assign cpu_clock = clk_reg;
    assign cpu_rise = rise_reg;

endmodule

// [verilog/cgu_wakeup.sv]
// Wake-up timer holding off the CPU clock until the oscillator settles.
`timescale 1ns/10ps
module cgu_wakeup #(
    parameter int EXTRA_CYCLES = cgu_pkg::WAKE_EXTRA_CYCLES,
    parameter int CNT_W = cgu_pkg::WAKE_CNT_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control
    input wire logic start,
    input wire logic long_delay,
    input wire logic root_tick,
    // Status
    output logic done
);

    typedef enum logic [1:0] {
        WK_IDLE = 2'h0,
        WK_ROOT = 2'h1,
        WK_TIME = 2'h2,
        WK_DONE = 2'h3
    } cgu_wake_state_type;

    cgu_wake_state_type state_reg;
    cgu_wake_state_type state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic done_reg;
    logic [CNT_W-1:0] root_last;
    logic [CNT_W-1:0] time_last;
    logic [CNT_W-1:0] cnt_inc;

    // Root cycle count depends on whether a crystal is fitted.
    assign root_last = long_delay ?
        CNT_W'(cgu_pkg::WAKE_XTAL_ROOT_CYCLES - 1) :
        CNT_W'(cgu_pkg::WAKE_OTHER_ROOT_CYCLES - 1);
    assign time_last = CNT_W'(EXTRA_CYCLES - 1);
    assign cnt_inc = CNT_W'(cnt_reg + 1'b1);

    // Root cycles first, then the fixed settling time; start restarts.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            WK_IDLE, WK_DONE:
            begin
                cnt_next = '0;
            end
            WK_ROOT:
            begin
                if (root_tick)
                begin
                    cnt_next = (cnt_reg == root_last) ? '0 : cnt_inc;
                    if (cnt_reg == root_last)
                        state_next = WK_TIME;
                end
            end
            WK_TIME:
            begin
                cnt_next = cnt_inc;
                if (cnt_reg == time_last)
                    state_next = WK_DONE;
            end
        endcase
        if (start)
        begin
            state_next = WK_ROOT;
            cnt_next = '0;
        end
    end

    // Timer state.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= WK_IDLE;
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= (state_next == WK_DONE);
        end
    end

    assign done = done_reg;

endmodule

// [tb/cgu_monitor.sv]
// Concurrent checks on the clock generation unit ports.
`timescale 1ns/10ps
module cgu_monitor #(
    parameter logic [5:0] FACTORY_TRIM = 6'h20,
    parameter int WAKE_EXTRA_CYCLES = 20
) (
    // Clock and resets
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic por_n,
    // Inputs watched
    input wire logic rtc_uses_crystal,
    input wire logic avs_read,
    input wire logic avs_write,
    // Outputs watched
    input wire logic avs_waitrequest,
    input wire logic cpu_clock,
    input wire logic cpu_clock_tick,
    input wire logic periph_clock,
    input wire logic machine_cycle_tick,
    input wire logic crystal_amp_enable,
    input wire logic [1:0] crystal_range,
    input wire logic rc_osc_enable,
    input wire logic [5:0] rc_trim,
    input wire logic low_power_clocking_bit,
    input wire logic crystal_out_or_clock_pin_oe
);
    // A root tick takes at least two system cycles.
    localparam int MIN_HOLD = 448 + WAKE_EXTRA_CYCLES;
    logic [1:0] mc_cnt;
    logic [15:0] up_cnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Tick and uptime counters.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mc_cnt <= 2'h0;
            up_cnt <= 16'h0;
        end
        else
        begin
            if (machine_cycle_tick)
                mc_cnt <= 2'h0;
            else if (cpu_clock_tick)
                mc_cnt <= mc_cnt + 2'h1;
            if (up_cnt != 16'hFFFF)
                up_cnt <= up_cnt + 16'h1;
        end
    end
    a_mc_pair: assert property (machine_cycle_tick |-> mc_cnt == 2'h2)
        else $error("machine tick without two CPU ticks");
    a_mc_bound: assert property (mc_cnt != 2'h3)
        else $error("machine tick missing");
    a_periph_half: assert property ($changed(periph_clock) |->
        cpu_clock_tick || $past(cpu_clock_tick))
        else $error("peripheral clock moved without CPU tick");
    a_pin_busy: assert property ((crystal_amp_enable || rtc_uses_crystal) &&
        $past(crystal_amp_enable || rtc_uses_crystal)
        |-> !crystal_out_or_clock_pin_oe)
        else $error("clock pin driven while crystal busy");
    a_range_amp: assert property (crystal_amp_enable ==
        (crystal_range != cgu_pkg::RANGE_OFF))
        else $error("crystal range and amplifier disagree");
    a_src_excl: assert property (!(rc_osc_enable && crystal_amp_enable))
        else $error("two oscillator sources enabled");
    a_wake_hold: assert property (cpu_clock |-> int'(up_cnt) >= MIN_HOLD)
        else $error("CPU clock before wake-up delay");
    a_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus wait state wrong");
    a_lp_reset: assert property (!$past(rstn) |-> !low_power_clocking_bit)
        else $error("low power bit set after reset");
    a_trim_por: assert property (disable iff (!por_n)
        $rose(por_n) |-> rc_trim == FACTORY_TRIM)
        else $error("trim not factory after power-on");
    a_trim_keep: assert property (disable iff (!por_n) $changed(rc_trim)
        |-> $past(avs_write) || $past(avs_write, 2))
        else $error("trim changed without write");
    // Main scenarios reached.
    c_machine: cover property (machine_cycle_tick);
    c_pin_on: cover property ($rose(crystal_out_or_clock_pin_oe));
    c_low_power: cover property ($rose(low_power_clocking_bit));
endmodule

bind cgu_top cgu_monitor #(.FACTORY_TRIM(FACTORY_TRIM),
    .WAKE_EXTRA_CYCLES(WAKE_EXTRA_CYCLES)) cgu_monitor_inst (.*);

// [tb/cgu_osc_model.sv]
// Behavioural oscillator sources feeding the clock generation unit.
`timescale 1ns/10ps
module cgu_osc_model #(
    // Half periods in ns; the watchdog source is sped up for simulation.
    parameter realtime XTAL_HALF = 42.5,
    parameter realtime RC_HALF = 67.5,
    parameter realtime WDT_HALF = 75.0
) (
    // Oscillator outputs
    output logic crystal_in_pin,
    output logic rc_osc_clock,
    output logic wdt_osc_clock
);
    // Crystal or external clock at 11.76 MHz, below the 12 MHz ceiling.
    initial
    begin
        crystal_in_pin = 1'b0;
        #1.3;
        forever #XTAL_HALF crystal_in_pin = ~crystal_in_pin;
    end
    // RC oscillator near its nominal rate.
    initial
    begin
        rc_osc_clock = 1'b0;
        #2.1;
        forever #RC_HALF rc_osc_clock = ~rc_osc_clock;
    end
    // Watchdog oscillator, free running.
    initial
    begin
        wdt_osc_clock = 1'b0;
        #3.7;
        forever #WDT_HALF wdt_osc_clock = ~wdt_osc_clock;
    end
endmodule

// [tb/testbench.sv]
// Self-checking testbench of the clock generation unit.
`timescale 1ns/10ps
module testbench;
    localparam logic [5:0] FT = 6'h15;
    localparam int XW = 20;
    logic sys_clk, rstn, por_n, rtc_uses_crystal, wake_request;
    logic port_out, port_oe, avs_read, avs_write, avs_waitrequest;
    logic [2:0] osc_config;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    wire logic crystal_in_pin, rc_osc_clock, wdt_osc_clock;
    logic root_osc_clock, cpu_clock, cpu_clock_tick, periph_clock;
    logic machine_cycle_tick, crystal_amp_enable, rc_osc_enable;
    logic [1:0] crystal_range;
    logic [5:0] rc_trim;
    logic low_power_clocking_bit;
    logic crystal_out_or_clock_pin_out, crystal_out_or_clock_pin_oe;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    logic [2:0] cfgs [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h3};

    cgu_top #(.FACTORY_TRIM(FT), .WAKE_EXTRA_CYCLES(XW)) cgu_top_inst (
        .avs_byteenable(4'hF), .*);
    cgu_osc_model cgu_osc_model_inst (.*);

    // System clock at 200 MHz.
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Cuts a hang short.
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            n_errors++;
            $display("Error at %0t: timeout", $time);
            test_done();
        end
    end

    task test_done();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    task automatic reset_dut(input logic [2:0] cfg, input logic por);
        osc_config <= cfg;
        rstn <= 1'b0;
        por_n <= !por;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
    endtask

    // One Avalon-MM access, held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk(32'(n < 100), 32'h1, "bus answer");
    endtask

    // Cycles to the next rise of the CPU clock or of the clock pin, or between two rises when k0 is 0.
    task automatic gap(input logic pin, input int k0, output int c);
        int k, n;
        logic p, v;
        k = k0;
        n = 0;
        c = 0;
        p = 1'b1;
        while (k < 2 && n < 30000)
        begin
            @(posedge sys_clk);
            n++;
            v = pin ? crystal_out_or_clock_pin_out : cpu_clock;
            if (k == 1)
                c++;
            if (v === 1'b1 && p === 1'b0)
                k++;
            p = v;
        end
    endtask

    task automatic t_regs();
        logic [31:0] q;
        reset_dut(3'h3, 1'b1);
        bus(1'b0, cgu_pkg::OFS_TRIM, 32'h0, q);
        chk(q, 32'(FT), "trim reset");
        bus(1'b1, cgu_pkg::OFS_TRIM, 32'h6A, q);
        bus(1'b1, cgu_pkg::OFS_AUX1, 32'h80, q);
        bus(1'b1, cgu_pkg::OFS_STATUS, 32'hFF, q);
        bus(1'b0, cgu_pkg::OFS_STATUS, 32'h0, q);
        chk(q & 32'h7, 32'h3, "status read only");
        bus(1'b1, 4'h2, 32'hFF, q);
        bus(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0, "unmapped read");
        chk(32'(rc_trim), 32'h2A, "trim port");
        chk(32'(low_power_clocking_bit), 32'h1, "low power set");
        reset_dut(3'h3, 1'b0);
        bus(1'b0, cgu_pkg::OFS_TRIM, 32'h0, q);
        chk(q, 32'h6A, "trim kept");
        bus(1'b0, cgu_pkg::OFS_AUX1, 32'h0, q);
        chk(q, 32'h0, "low power cleared");
        reset_dut(3'h3, 1'b1);
        bus(1'b0, cgu_pkg::OFS_TRIM, 32'h0, q);
        chk(q, 32'(FT), "trim reloaded");
        $display("t_regs done");
    endtask

    task automatic t_wake(input logic [2:0] cfg);
        int n, p, lo;
        logic [31:0] q;
        logic [3:0] e;
        p = (cfg == 3'h3) ? 27 : (cfg == 3'h4) ? 30 : 17;
        n = ((cfg < 3'h3) ? 992 : 224) * p + XW;
        e = (cfg < 3'h3) ? {1'b1, cfg[1:0] + 2'h1, 1'b0} : {3'h0, cfg == 3'h3};
        reset_dut(cfg, 1'b0);
        gap(1'b0, 1, lo);
        chk(32'(lo >= n - p && lo <= n + 2 * p + 12), 32'h1, "wake");
        bus(1'b0, cgu_pkg::OFS_STATUS, 32'h0, q);
        chk(q & 32'h2F, 32'({cfg < 3'h3, 2'h1, cfg}), "status");
        chk(32'({crystal_amp_enable, crystal_range, rc_osc_enable}), 32'(e),
            "source controls");
        $display("t_wake %0d done", cfg);
    endtask

    task automatic t_pin();
        int c;
        logic [31:0] q;
        @(posedge sys_clk);
        port_out <= 1'b1;
        port_oe <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(32'({crystal_out_or_clock_pin_oe, crystal_out_or_clock_pin_out}),
            32'h1, "port drive");
        bus(1'b1, cgu_pkg::OFS_TRIM, 32'h40 | 32'(FT), q);
        gap(1'b1, 0, c);
        chk(32'(c), 32'd54, "pin period");
        chk(32'(crystal_out_or_clock_pin_oe), 32'h1, "pin on");
        rtc_uses_crystal <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(32'(crystal_out_or_clock_pin_oe), 32'h0, "rtc busy");
        rtc_uses_crystal <= 1'b0;
        $display("t_pin done");
    endtask

    task automatic div_meas(input logic [7:0] v);
        int c;
        logic [31:0] q;
        gap(1'b0, 1, c);
        bus(1'b1, cgu_pkg::OFS_DIV, 32'(v), q);
        gap(1'b0, 1, c);
        gap(1'b0, 1, c);
        chk(32'(c), 32'((v == 8'h0) ? 27 : 54 * v), "cpu period");
        if (v == 8'h0) chk(32'(root_osc_clock), 32'h1, "root");
    endtask

    task automatic t_div();
        int c;
        logic [31:0] q;
        div_meas(8'h00);
        div_meas(8'h01);
        div_meas(8'h03);
        fork
            gap(1'b0, 1, c);
            begin
                repeat (30) @(posedge sys_clk);
                bus(1'b1, cgu_pkg::OFS_DIV, 32'h1, q);
            end
        join
        chk(32'(c), 32'd162, "old ratio kept");
        gap(1'b0, 1, c);
        chk(32'(c), 32'd54, "new ratio");
        div_meas(8'hFF);
        $display("t_div done");
    endtask

    // Main sequence.
    initial
    begin
        {rtc_uses_crystal, wake_request, port_out, avs_read, avs_write} = '0;
        port_oe = 1'b1;
        {avs_address, avs_writedata} = '0;
        t_regs();
        foreach (cfgs[i])
            t_wake(cfgs[i]);
        t_pin();
        t_div();
        test_done();
    end
endmodule
